// file: core/pte_channel.sv
`timescale 1ns/1ps
// one channel: output level tracking and input edge detection
module pte_channel (
    input  wire logic              pclk,
    input  wire logic              presetn,
    input  wire pte_pkg::pte_cfg_t cfg,
    input  wire pte_pkg::pte_task_t task_req,
    input  wire logic              pin_level,
    output logic                   out_level,
    output logic                   edge_hit
);
    typedef struct packed {
        logic lvl;
        logic prev_in;
        logic was_task;
    } pte_ch_state_t;
    pte_ch_state_t st_reg, st_next;
    logic rise, fall;

    always_comb begin
        st_next = st_reg;
        st_next.prev_in = pin_level;
        st_next.was_task = (cfg.mode == pte_pkg::MODE_TASK);
        rise = pin_level & ~st_reg.prev_in;
        fall = ~pin_level & st_reg.prev_in;
        edge_hit = 1'b0;
        if (cfg.mode == pte_pkg::MODE_TASK) begin
            if (!st_reg.was_task) begin
                st_next.lvl = cfg.init;
            end else if (task_req.clear) begin
                st_next.lvl = 1'b0;
            end else if (task_req.set) begin
                st_next.lvl = 1'b1;
            end else if (task_req.drive) begin
                unique case (cfg.pol)
                    pte_pkg::POL_NONE:   st_next.lvl = st_reg.lvl;
                    pte_pkg::POL_RISE:   st_next.lvl = 1'b1;
                    pte_pkg::POL_FALL:   st_next.lvl = 1'b0;
                    pte_pkg::POL_TOGGLE: st_next.lvl = ~st_reg.lvl;
                endcase
            end
        end
        if (cfg.mode == pte_pkg::MODE_EVENT) begin
            unique case (cfg.pol)
                pte_pkg::POL_NONE:   edge_hit = 1'b0;
                pte_pkg::POL_RISE:   edge_hit = rise;
                pte_pkg::POL_FALL:   edge_hit = fall;
                pte_pkg::POL_TOGGLE: edge_hit = rise | fall;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign out_level = st_reg.lvl;

    property p_set_high;
        @(posedge pclk) disable iff (!presetn)
        (cfg.mode == pte_pkg::MODE_TASK && st_reg.was_task
         && task_req.set && !task_req.clear) |=> out_level;
    endproperty
    a_set_high: assert property (p_set_high)
        else $error("set task did not raise level");

    property p_clear_low;
        @(posedge pclk) disable iff (!presetn)
        (cfg.mode == pte_pkg::MODE_TASK && st_reg.was_task
         && task_req.clear) |=> !out_level;
    endproperty
    a_clear_low: assert property (p_clear_low)
        else $error("clear task did not lower level");

    property p_toggle;
        @(posedge pclk) disable iff (!presetn)
        (cfg.mode == pte_pkg::MODE_TASK && st_reg.was_task
         && task_req == 3'b100 && cfg.pol == pte_pkg::POL_TOGGLE)
        |=> out_level != $past(out_level);
    endproperty
    a_toggle: assert property (p_toggle)
        else $error("toggle drive task did not invert level");

    property p_init;
        @(posedge pclk) disable iff (!presetn)
        (cfg.mode == pte_pkg::MODE_TASK && !st_reg.was_task)
        |=> out_level == $past(cfg.init);
    endproperty
    a_init: assert property (p_init)
        else $error("initial level not applied on task entry");
endmodule : pte_channel

// file: core/pte_pkg.sv
// Operation
// - drive task applies polarity action to pin
// - set task drives selected pin high
// - clear task drives selected pin low
// - per-channel input event flag, software writable
// - port event flag set by sense trigger
// - enable-set writes one enable channel irq
// - enable-set port bit enables port irq
// - enable-clear writes one disable channel irq
// - enable-clear port bit disables port irq
// - eight channel configuration registers at 0x510
// - mode 0 disabled, 1 event, 3 task
// - polarity none, rising, falling, toggle
// - task mode pin overrides port output
// - entering task mode loads initial level
package pte_pkg;
    localparam int unsigned NCH = 8;
    localparam int unsigned NPIN = 32;
    localparam logic [11:0] OFF_DRIVE = 12'h000;
    localparam logic [11:0] OFF_SET = 12'h030;
    localparam logic [11:0] OFF_CLEAR = 12'h060;
    localparam logic [11:0] OFF_EVENT = 12'h100;
    localparam logic [11:0] OFF_PORT = 12'h17C;
    localparam logic [11:0] OFF_IRQ_SET = 12'h304;
    localparam logic [11:0] OFF_IRQ_CLR = 12'h308;
    localparam logic [11:0] OFF_CONFIG = 12'h510;
    localparam logic [11:0] CH_SPAN = 12'h020;
    localparam int unsigned PORT_BIT = 31;
    // config field layout
    localparam int unsigned MODE_LSB = 0;
    localparam int unsigned PSEL_LSB = 8;
    localparam int unsigned POL_LSB = 16;
    localparam int unsigned INIT_BIT = 20;
    localparam logic [31:0] CFG_MASK = 32'h0013_1F03;
    localparam logic [1:0] MODE_OFF = 2'h0;
    localparam logic [1:0] MODE_EVENT = 2'h1;
    localparam logic [1:0] MODE_TASK = 2'h3;
    localparam logic [1:0] POL_NONE = 2'h0;
    localparam logic [1:0] POL_RISE = 2'h1;
    localparam logic [1:0] POL_FALL = 2'h2;
    localparam logic [1:0] POL_TOGGLE = 2'h3;

    typedef struct packed {
        logic [1:0] mode;
        logic [4:0] pin;
        logic [1:0] pol;
        logic       init;
    } pte_cfg_t;

    typedef struct packed {
        logic drive;
        logic set;
        logic clear;
    } pte_task_t;
endpackage : pte_pkg

// file: core/pte_unit.sv
// Added by the designer: register access over APB.
`timescale 1ns/1ps
// pin task/event unit, APB slave, zero wait states
module pte_unit #(
    parameter int unsigned NCH = pte_pkg::NCH
) (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic [31:0] pin_in,
    input  wire logic        sense_trigger,
    input  wire logic [31:0] port_out,
    input  wire logic [31:0] port_oe,
    output logic      [31:0] pin_out,
    output logic      [31:0] pin_oe,
    output logic             irq
);
    typedef struct packed {
        logic [NCH-1:0]       ev;
        logic                 port_ev;
        logic [NCH-1:0]       ien;
        logic                 port_ien;
        logic [NCH-1:0][31:0] cfg;
        logic [31:0]          rdata;
    } pte_state_t;
    pte_state_t st_reg, st_next;

    pte_pkg::pte_cfg_t  cfg_f [NCH];
    pte_pkg::pte_task_t tsk [NCH];
    logic [NCH-1:0] lvl, hit;
    logic wr, rd_setup, hit_map;

    assign wr = psel & penable & pwrite;
    // read word is captured in the setup cycle so prdata is a flop output
    assign rd_setup = psel & ~penable & ~pwrite;
    assign pready = 1'b1;

    genvar g;
    generate
        for (g = 0; g < NCH; g++) begin : gen_ch
            always_comb begin
                cfg_f[g].mode = st_reg.cfg[g][pte_pkg::MODE_LSB +: 2];
                cfg_f[g].pin = st_reg.cfg[g][pte_pkg::PSEL_LSB +: 5];
                cfg_f[g].pol = st_reg.cfg[g][pte_pkg::POL_LSB +: 2];
                cfg_f[g].init = st_reg.cfg[g][pte_pkg::INIT_BIT];
                tsk[g].drive = wr && pwdata[0]
                    && paddr == pte_pkg::OFF_DRIVE + 12'(4 * g);
                tsk[g].set = wr && pwdata[0]
                    && paddr == pte_pkg::OFF_SET + 12'(4 * g);
                tsk[g].clear = wr
                    && paddr == pte_pkg::OFF_CLEAR + 12'(4 * g);
            end
            pte_channel u_ch (
                .pclk      (pclk),
                .presetn   (presetn),
                .cfg       (cfg_f[g]),
                .task_req  (tsk[g]),
                .pin_level (pin_in[cfg_f[g].pin]),
                .out_level (lvl[g]),
                .edge_hit  (hit[g])
            );
        end
    endgenerate

    // pin override; later channel wins if software double-assigns a pin
    always_comb begin
        pin_out = port_out;
        pin_oe = port_oe;
        for (int i = 0; i < NCH; i++) begin
            if (cfg_f[i].mode == pte_pkg::MODE_TASK) begin
                pin_out[cfg_f[i].pin] = lvl[i];
                pin_oe[cfg_f[i].pin] = 1'b1;
            end else if (cfg_f[i].mode == pte_pkg::MODE_EVENT) begin
                pin_oe[cfg_f[i].pin] = 1'b0;
            end
        end
    end

    always_comb begin
        st_next = st_reg;
        st_next.rdata = '0;
        for (int i = 0; i < NCH; i++) begin
            if (wr && paddr == pte_pkg::OFF_EVENT + 12'(4 * i)) begin
                st_next.ev[i] = pwdata[0];
            end
            if (hit[i]) begin
                st_next.ev[i] = 1'b1;
            end
            if (wr && paddr == pte_pkg::OFF_CONFIG + 12'(4 * i)) begin
                st_next.cfg[i] = pwdata & pte_pkg::CFG_MASK;
            end
            if (rd_setup && paddr == pte_pkg::OFF_EVENT + 12'(4 * i)) begin
                st_next.rdata = {31'h0, st_reg.ev[i]};
            end
            if (rd_setup && paddr == pte_pkg::OFF_CONFIG + 12'(4 * i)) begin
                st_next.rdata = st_reg.cfg[i];
            end
        end
        if (wr && paddr == pte_pkg::OFF_PORT) begin
            st_next.port_ev = pwdata[0];
        end
        if (sense_trigger) begin
            st_next.port_ev = 1'b1;
        end
        if (wr && paddr == pte_pkg::OFF_IRQ_SET) begin
            st_next.ien = st_reg.ien | pwdata[NCH-1:0];
            st_next.port_ien = st_reg.port_ien
                | pwdata[pte_pkg::PORT_BIT];
        end
        if (wr && paddr == pte_pkg::OFF_IRQ_CLR) begin
            st_next.ien = st_reg.ien & ~pwdata[NCH-1:0];
            st_next.port_ien = st_reg.port_ien
                & ~pwdata[pte_pkg::PORT_BIT];
        end
        if (rd_setup && paddr == pte_pkg::OFF_PORT) begin
            st_next.rdata = {31'h0, st_reg.port_ev};
        end
        if (rd_setup && (paddr == pte_pkg::OFF_IRQ_SET
                   || paddr == pte_pkg::OFF_IRQ_CLR)) begin
            st_next.rdata = '0;
            st_next.rdata[NCH-1:0] = st_reg.ien;
            st_next.rdata[pte_pkg::PORT_BIT] = st_reg.port_ien;
        end
    end

    // zero wait still holds: the word stands through the whole access phase
    assign prdata = st_reg.rdata;

    // task registers are write-only strobes; unmapped reads give zero
    always_comb begin
        hit_map = 1'b0;
        for (int i = 0; i < NCH; i++) begin
            if (paddr == pte_pkg::OFF_DRIVE + 12'(4 * i)
                || paddr == pte_pkg::OFF_SET + 12'(4 * i)
                || paddr == pte_pkg::OFF_CLEAR + 12'(4 * i)
                || paddr == pte_pkg::OFF_EVENT + 12'(4 * i)
                || paddr == pte_pkg::OFF_CONFIG + 12'(4 * i)) begin
                hit_map = 1'b1;
            end
        end
        if (paddr == pte_pkg::OFF_PORT || paddr == pte_pkg::OFF_IRQ_SET
            || paddr == pte_pkg::OFF_IRQ_CLR) begin
            hit_map = 1'b1;
        end
    end
    assign pslverr = psel & penable & ~hit_map;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign irq = |(st_reg.ev & st_reg.ien)
        | (st_reg.port_ev & st_reg.port_ien);

    property p_event_set;
        @(posedge pclk) disable iff (!presetn)
        hit[NCH-1] |=> st_reg.ev[NCH-1];
    endproperty
    a_event_set: assert property (p_event_set)
        else $error("channel event not flagged");

    property p_port_set;
        @(posedge pclk) disable iff (!presetn)
        sense_trigger |=> st_reg.port_ev;
    endproperty
    a_port_set: assert property (p_port_set)
        else $error("port event not flagged");

    property p_ien_set;
        @(posedge pclk) disable iff (!presetn)
        (wr && paddr == pte_pkg::OFF_IRQ_SET && pwdata[NCH-1])
        |=> st_reg.ien[NCH-1];
    endproperty
    a_ien_set: assert property (p_ien_set)
        else $error("enable-set did not enable");

    property p_ien_clr;
        @(posedge pclk) disable iff (!presetn)
        (wr && paddr == pte_pkg::OFF_IRQ_CLR && pwdata[NCH-1])
        |=> !st_reg.ien[NCH-1];
    endproperty
    a_ien_clr: assert property (p_ien_clr)
        else $error("enable-clear did not disable");

    property p_irq;
        @(posedge pclk) disable iff (!presetn)
        (st_reg.port_ev && st_reg.port_ien) |-> irq;
    endproperty
    a_irq: assert property (p_irq)
        else $error("irq missing for enabled port event");

    property p_task_oe;
        @(posedge pclk) disable iff (!presetn)
        (cfg_f[0].mode == pte_pkg::MODE_TASK)
        |-> pin_oe[cfg_f[0].pin] && pin_out[cfg_f[0].pin] == lvl[0];
    endproperty
    a_task_oe: assert property (p_task_oe)
        else $error("task pin not driven by its channel");

    property p_event_in;
        @(posedge pclk) disable iff (!presetn)
        (cfg_f[NCH-1].mode == pte_pkg::MODE_EVENT)
        |-> !pin_oe[cfg_f[NCH-1].pin];
    endproperty
    a_event_in: assert property (p_event_in)
        else $error("event pin still driven");
endmodule : pte_unit

// file: sim/pte_pins.sv
`timescale 1ns/1ps
// far side: pads and port sense logic
module pte_pins (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic [31:0] pin_out,
    input  wire logic [31:0] pin_oe,
    input  wire logic [31:0] ext_level,
    input  wire logic        sense_req,
    output logic      [31:0] pin_in,
    output logic             sense_trigger
);
    // registered, so the unit sees pad levels a cycle late as on silicon
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin_in        <= 32'h0000_0000;
            sense_trigger <= 1'b0;
        end else begin
            pin_in        <= (pin_out & pin_oe) | (ext_level & ~pin_oe);
            sense_trigger <= sense_req;
        end
    end
endmodule : pte_pins

// file: sim/tb_top.sv
`timescale 1ns/1ps
module tb_top;
    logic        pclk = 1'b0;
    logic        presetn = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic [31:0] pin_in;
    logic        sense_trigger;
    logic [31:0] port_out = 32'hA5A5_0F0F;
    logic [31:0] port_oe = 32'hFFFF_FFFF;
    logic [31:0] pin_out;
    logic [31:0] pin_oe;
    logic        irq;
    logic [31:0] ext_level = 32'h0000_0000;
    logic        sense_req = 1'b0;
    logic [31:0] rd_data;
    logic        rd_err;
    int          errors = 0;
    int          tests_run = 0;

    always #4 pclk = ~pclk;

    pte_unit DUT (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .pin_in(pin_in), .sense_trigger(sense_trigger),
        .port_out(port_out), .port_oe(port_oe), .pin_out(pin_out),
        .pin_oe(pin_oe), .irq(irq));

    pte_pins u_pins (.pclk(pclk), .presetn(presetn), .pin_out(pin_out),
        .pin_oe(pin_oe), .ext_level(ext_level), .sense_req(sense_req),
        .pin_in(pin_in), .sense_trigger(sense_trigger));

    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", tests_run, errors);
        if (errors == 0 && tests_run > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : tally_and_finish

    task automatic apb(input logic wr, input logic [11:0] a,
                       input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) begin
            @(posedge pclk);
        end
        rd_data = prdata;
        rd_err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic chk(input string nm, input logic [31:0] e,
                       input logic [31:0] g);
        tests_run++;
        if (g !== e) begin
            errors++;
            $display("mismatch %s expected %h seen %h", nm, e, g);
        end
    endtask : chk

    task automatic rchk(input logic [11:0] a, input logic [31:0] e,
                        input string nm);
        apb(1'b0, a, 32'h0000_0000);
        chk(nm, e, rd_data);
    endtask : rchk

    // task and event effects land a cycle or two after the access
    task automatic settle;
        repeat (3) @(posedge pclk);
        #1;
    endtask : settle

    function automatic logic [31:0] cfg(input logic [1:0] m,
        input logic [4:0] p, input logic [1:0] pol, input logic i);
        return {11'h000, i, 2'h0, pol, 3'h0, p, 6'h00, m};
    endfunction : cfg

    initial begin
        repeat (20000) @(posedge pclk);
        errors++;
        tally_and_finish();
    end

    initial begin
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        rchk(pte_pkg::OFF_EVENT, 32'h0, "event0");
        rchk(pte_pkg::OFF_PORT, 32'h0, "port_event");
        rchk(pte_pkg::OFF_IRQ_SET, 32'h0, "irq_set");
        rchk(pte_pkg::OFF_IRQ_CLR, 32'h0, "irq_clr");
        chk("pin_out", port_out, pin_out);
        chk("pin_oe", port_oe, pin_oe);
        chk("irq", 32'h0, {31'h0, irq});
        $display("test reset done");
        port_oe[5] <= 1'b0;
        apb(1'b1, pte_pkg::OFF_CONFIG,
            cfg(pte_pkg::MODE_TASK, 5'h05, pte_pkg::POL_TOGGLE, 1'b1));
        settle();
        chk("oe5", 32'h1, {31'h0, pin_oe[5]});
        chk("init5", 32'h1, {31'h0, pin_out[5]});
        apb(1'b1, pte_pkg::OFF_CLEAR, 32'h0000_0000);
        settle();
        chk("clear5", 32'h0, {31'h0, pin_out[5]});
        apb(1'b1, pte_pkg::OFF_SET, 32'h0000_0001);
        settle();
        chk("set5", 32'h1, {31'h0, pin_out[5]});
        apb(1'b1, pte_pkg::OFF_DRIVE, 32'h0000_0001);
        settle();
        chk("toggle5", 32'h0, {31'h0, pin_out[5]});
        // init chosen so every polarity code moves or holds visibly
        for (int p = 0; p < 4; p++) begin
            apb(1'b1, pte_pkg::OFF_CONFIG + 12'(4 * (p + 1)),
                cfg(pte_pkg::MODE_TASK, 5'(8 + p), 2'(p), ~p[0]));
            settle();
            apb(1'b1, pte_pkg::OFF_DRIVE + 12'(4 * (p + 1)), 32'h1);
            settle();
            chk("drive_pol", (p == 2) ? 32'h0 : 32'h1,
                {31'h0, pin_out[8 + p]});
        end
        $display("test task mode done");
        apb(1'b1, pte_pkg::OFF_CONFIG + 12'h01C,
            cfg(pte_pkg::MODE_EVENT, 5'h14, pte_pkg::POL_RISE, 1'b0));
        settle();
        chk("oe20", 32'h0, {31'h0, pin_oe[20]});
        @(posedge pclk);
        ext_level[20] <= 1'b1;
        settle();
        rchk(pte_pkg::OFF_EVENT + 12'h01C, 32'h1, "event7");
        apb(1'b1, pte_pkg::OFF_IRQ_SET, 32'h0000_0080);
        settle();
        chk("irq_ch", 32'h1, {31'h0, irq});
        rchk(pte_pkg::OFF_IRQ_SET, 32'h0000_0080, "irq_set");
        rchk(pte_pkg::OFF_IRQ_CLR, 32'h0000_0080, "irq_clr");
        apb(1'b1, pte_pkg::OFF_IRQ_CLR, 32'h0000_0080);
        settle();
        chk("irq_off", 32'h0, {31'h0, irq});
        apb(1'b1, pte_pkg::OFF_EVENT + 12'h01C, 32'h0000_0000);
        rchk(pte_pkg::OFF_EVENT + 12'h01C, 32'h0, "event7_wr");
        @(posedge pclk);
        ext_level[20] <= 1'b0;
        settle();
        rchk(pte_pkg::OFF_EVENT + 12'h01C, 32'h0, "event7_fall");
        apb(1'b1, pte_pkg::OFF_CONFIG + 12'h01C,
            cfg(pte_pkg::MODE_EVENT, 5'h14, pte_pkg::POL_FALL, 1'b0));
        @(posedge pclk);
        ext_level[20] <= 1'b1;
        settle();
        rchk(pte_pkg::OFF_EVENT + 12'h01C, 32'h0, "ev7_fall_up");
        @(posedge pclk);
        ext_level[20] <= 1'b0;
        settle();
        rchk(pte_pkg::OFF_EVENT + 12'h01C, 32'h1, "ev7_fall_dn");
        apb(1'b1, pte_pkg::OFF_EVENT + 12'h01C, 32'h0000_0000);
        apb(1'b1, pte_pkg::OFF_CONFIG + 12'h01C,
            cfg(pte_pkg::MODE_EVENT, 5'h14, pte_pkg::POL_TOGGLE, 1'b0));
        @(posedge pclk);
        ext_level[20] <= 1'b1;
        settle();
        rchk(pte_pkg::OFF_EVENT + 12'h01C, 32'h1, "ev7_any_up");
        apb(1'b1, pte_pkg::OFF_EVENT + 12'h01C, 32'h0000_0000);
        @(posedge pclk);
        ext_level[20] <= 1'b0;
        settle();
        rchk(pte_pkg::OFF_EVENT + 12'h01C, 32'h1, "ev7_any_dn");
        apb(1'b1, pte_pkg::OFF_EVENT + 12'h01C, 32'h0000_0000);
        $display("test event mode done");
        @(posedge pclk);
        sense_req <= 1'b1;
        @(posedge pclk);
        sense_req <= 1'b0;
        settle();
        rchk(pte_pkg::OFF_PORT, 32'h1, "port_event");
        apb(1'b1, pte_pkg::OFF_IRQ_SET, 32'h8000_0000);
        apb(1'b1, pte_pkg::OFF_IRQ_SET, 32'h0000_0000);
        rchk(pte_pkg::OFF_IRQ_SET, 32'h8000_0000, "irq_port");
        chk("irq_port_on", 32'h1, {31'h0, irq});
        apb(1'b1, pte_pkg::OFF_IRQ_CLR, 32'h0000_0000);
        rchk(pte_pkg::OFF_IRQ_CLR, 32'h8000_0000, "irq_keep");
        apb(1'b1, pte_pkg::OFF_IRQ_CLR, 32'h8000_0000);
        rchk(pte_pkg::OFF_IRQ_SET, 32'h0, "irq_port_off");
        apb(1'b1, pte_pkg::OFF_PORT, 32'h0000_0000);
        rchk(pte_pkg::OFF_PORT, 32'h0, "port_wr");
        $display("test port event done");
        apb(1'b0, 12'h200, 32'h0000_0000);
        chk("slverr", 32'h1, {31'h0, rd_err});
        apb(1'b1, pte_pkg::OFF_CONFIG + 12'h018, 32'hFFFF_FFFF);
        rchk(pte_pkg::OFF_CONFIG + 12'h018, pte_pkg::CFG_MASK, "cfg6");
        $display("test map done");
        tally_and_finish();
    end
endmodule : tb_top
